// ===== asr_host.sv
/*
 * host controller for a 512K x 8 asynchronous static memory: takes one
 * request at a time and sequences address, chip select, output enable,
 * write strobe and the shared data pins.
 * assumes the memory's pins are wired straight to the pin struct and the
 * data pins' level comes back on mem_dq_in; the testbench resolves the bus.
 */
`timescale 1ns/100ps
`default_nettype none
module asr_host #(
    parameter int unsigned RD_CYCLES  = asr_pkg::RD_CYC,
    parameter int unsigned WR_CYCLES  = asr_pkg::WR_CYC,
    parameter int unsigned STB_CYCLES = asr_pkg::STROBE_CYC,
    parameter int unsigned TURN_CYCLES = asr_pkg::HZ_CYC
) (
    input  wire logic                          sys_clk,
    input  wire logic                          reset_n,
    input  wire logic                          req_valid,
    output logic                               req_ready,
    input  wire asr_pkg::asr_req_s             req,
    output logic                               rd_valid,
    output logic [asr_pkg::DATA_W-1:0]         rd_data,
    output asr_pkg::asr_pins_s                 pins,
    input  wire logic [asr_pkg::DATA_W-1:0]    mem_dq_in
);

    // first flop takes the pins one cycle past the access time: data may settle right at that edge
    localparam logic [asr_pkg::CNT_W-1:0] RD_LAST   = asr_pkg::CNT_W'(RD_CYCLES + asr_pkg::SYNC_CYC);
    localparam logic [asr_pkg::CNT_W-1:0] RD_SAMPLE = asr_pkg::CNT_W'(RD_CYCLES + asr_pkg::SYNC_CYC);
    localparam logic [asr_pkg::CNT_W-1:0] WR_LAST   = asr_pkg::CNT_W'(WR_CYCLES - 1);
    localparam logic [asr_pkg::CNT_W-1:0] STB_END   = asr_pkg::CNT_W'(STB_CYCLES);
    localparam logic [asr_pkg::CNT_W-1:0] TURN_LAST = asr_pkg::CNT_W'(TURN_CYCLES - 1);

    asr_pkg::asr_state_e              state_reg;
    asr_pkg::asr_state_e              state_next;
    logic [asr_pkg::CNT_W-1:0]        cnt_reg;
    logic [asr_pkg::CNT_W-1:0]        cnt_next;
    asr_pkg::asr_pins_s               pins_reg;
    asr_pkg::asr_pins_s               pins_next;
    logic [asr_pkg::DATA_W-1:0]       rd_data_reg;
    logic [asr_pkg::DATA_W-1:0]       rd_data_next;
    logic                             rd_valid_reg;
    logic                             rd_valid_next;
    logic [asr_pkg::DATA_W-1:0]       dq_sync;

    asr_sync #(
        .W (asr_pkg::DATA_W)
    ) u_dq_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in (mem_dq_in),
        .sync_out (dq_sync)
    );

    // a new request is only taken from idle, so cycle times always elapse
    assign req_ready = (state_reg == asr_pkg::ASR_IDLE);

    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg + 1'b1;
        pins_next     = pins_reg;
        rd_data_next  = rd_data_reg;
        rd_valid_next = 1'b0;
        unique case (state_reg)
            asr_pkg::ASR_IDLE: begin
                cnt_next = '0;
                if (req_valid) begin
                    // address and select change on the same edge
                    pins_next.word_address = req.word_address;
                    pins_next.chip_sel_n   = 1'b0;
                    if (req.write) begin
                        pins_next.out_en_n    = 1'b1;
                        pins_next.wr_strobe_n = 1'b0;
                        pins_next.dq_out      = req.wdata;
                        pins_next.dq_oe_n     = 1'b0;
                        state_next            = asr_pkg::ASR_WRITE;
                    end else begin
                        pins_next.out_en_n    = 1'b0;
                        pins_next.wr_strobe_n = 1'b1;
                        pins_next.dq_oe_n     = 1'b1;
                        state_next            = asr_pkg::ASR_READ;
                    end
                end
            end
            asr_pkg::ASR_READ: begin
                // sample after access time plus synchroniser delay
                if (cnt_reg == RD_SAMPLE) begin
                    rd_data_next  = dq_sync;
                    rd_valid_next = 1'b1;
                end
                if (cnt_reg == RD_LAST) begin
                    pins_next.chip_sel_n = 1'b1;
                    pins_next.out_en_n   = 1'b1;
                    cnt_next             = '0;
                    state_next           = asr_pkg::ASR_TURN;
                end
            end
            asr_pkg::ASR_WRITE: begin
                // strobe and select rise together; data held one more cycle
                if (cnt_reg == STB_END - 1'b1) begin
                    pins_next.wr_strobe_n = 1'b1;
                    pins_next.chip_sel_n  = 1'b1;
                end
                if (cnt_reg == STB_END) begin
                    pins_next.dq_oe_n = 1'b1;
                end
                if (cnt_reg == WR_LAST) begin
                    cnt_next   = '0;
                    state_next = asr_pkg::ASR_IDLE;
                end
            end
            asr_pkg::ASR_TURN: begin
                // let the memory release the bus before the host may drive it
                if (cnt_reg == TURN_LAST) begin
                    cnt_next   = '0;
                    state_next = asr_pkg::ASR_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg             <= asr_pkg::ASR_IDLE;
            cnt_reg               <= '0;
            pins_reg.chip_sel_n   <= 1'b1;
            pins_reg.out_en_n     <= 1'b1;
            pins_reg.wr_strobe_n  <= 1'b1;
            pins_reg.word_address <= '0;
            pins_reg.dq_out       <= '0;
            pins_reg.dq_oe_n      <= 1'b1;
            rd_data_reg           <= '0;
            rd_valid_reg          <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            pins_reg     <= pins_next;
            rd_data_reg  <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    assign pins     = pins_reg;
    assign rd_data  = rd_data_reg;
    assign rd_valid = rd_valid_reg;

    property p_addr_stable_sel;
        @(posedge sys_clk) disable iff (!reset_n)
        !pins_reg.chip_sel_n && !$past(pins_reg.chip_sel_n) |-> $stable(pins_reg.word_address);
    endproperty
    a_addr_stable_sel: assert property (p_addr_stable_sel) else $error("address moved during access");

    property p_write_pulse;
        @(posedge sys_clk) disable iff (!reset_n)
        $fell(pins_reg.wr_strobe_n) |-> !pins_reg.wr_strobe_n [*7];
    endproperty
    a_write_pulse: assert property (p_write_pulse) else $error("write strobe too short");

    property p_write_data;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(pins_reg.wr_strobe_n) |-> !pins_reg.dq_oe_n && $stable(pins_reg.dq_out);
    endproperty
    a_write_data: assert property (p_write_data) else $error("write data not held to end");

    property p_write_ends_together;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(pins_reg.wr_strobe_n) |-> $rose(pins_reg.chip_sel_n);
    endproperty
    a_write_ends_together: assert property (p_write_ends_together) else $error("select and strobe split");

    property p_no_read_write;
        @(posedge sys_clk) disable iff (!reset_n)
        !pins_reg.dq_oe_n |-> pins_reg.out_en_n;
    endproperty
    a_no_read_write: assert property (p_no_read_write) else $error("host drives during read");

    property p_read_cycle;
        @(posedge sys_clk) disable iff (!reset_n)
        $fell(pins_reg.out_en_n) |-> !pins_reg.out_en_n [*8] ##1 !pins_reg.chip_sel_n;
    endproperty
    a_read_cycle: assert property (p_read_cycle) else $error("read cycle too short");

    property p_read_result;
        @(posedge sys_clk) disable iff (!reset_n)
        $fell(pins_reg.out_en_n) |-> ##[1:20] rd_valid_reg;
    endproperty
    a_read_result: assert property (p_read_result) else $error("read data not returned");

    property p_write_cycle;
        @(posedge sys_clk) disable iff (!reset_n)
        $fell(pins_reg.wr_strobe_n) |-> !req_ready [*8];
    endproperty
    a_write_cycle: assert property (p_write_cycle) else $error("write cycle too short");

endmodule
`default_nettype wire

// ===== asr_mem_model.sv
/*
 * behavioural 512K x 8 asynchronous static memory, the far side of asr_host.
 * assumes the testbench resolves the shared data pins from both drivers.
 */
`timescale 1ns/100ps
`default_nettype none
module asr_mem_model #(
    parameter real T_LZ = 10.0,
    parameter real T_OH = 5.0
) (
    input  wire logic        chip_sel_n,
    input  wire logic        out_en_n,
    input  wire logic        wr_strobe_n,
    input  wire logic [18:0] word_address,
    input  wire logic [7:0]  dq_bus,
    output logic             mem_drive,
    output logic [7:0]       mem_data
);
    real        t_acc = 45.0;
    logic [7:0] mem [logic [18:0]];
    int         gen = 0;
    logic       wr_act = 1'b0;
    logic [18:0] w_addr;
    logic [7:0] w_data;
    wire        rd_on = !chip_sel_n && !out_en_n && wr_strobe_n;

    initial begin
        mem_drive = 1'b0;
        mem_data = 8'h5A;
    end

    // floating pins show a changing pattern, never the last byte
    task automatic launch(int g);
        #(T_OH);
        if (g == gen) mem_data = ~mem_data;
        #(T_LZ - T_OH);
        if (g == gen && rd_on) mem_drive = 1'b1;
        #(t_acc - T_LZ);
        if (g == gen && rd_on) mem_data = mem.exists(word_address) ? mem[word_address] : 8'h00;
    endtask

    always @(chip_sel_n or out_en_n or wr_strobe_n or word_address) begin
        gen = gen + 1;
        if (!rd_on) mem_drive = 1'b0;
        fork
            launch(gen);
        join_none
    end

    always @(word_address or dq_bus or chip_sel_n or wr_strobe_n) begin
        if (!chip_sel_n && !wr_strobe_n) begin
            w_addr = word_address;
            w_data = dq_bus;
        end
    end

    // store at the first rise of select or strobe
    always @(chip_sel_n or wr_strobe_n) begin
        if (wr_act && (chip_sel_n || wr_strobe_n)) mem[w_addr] = w_data;
        wr_act = !chip_sel_n && !wr_strobe_n;
    end
endmodule
`default_nettype wire

// ===== asr_pkg.sv
/*
 * package for the asynchronous static memory host controller: pin timing,
 * widths and the carrier structs.
 * assumes a 200 MHz system clock.
 */
package asr_pkg;

    localparam int unsigned CLK_PERIOD_PS = 5000;

    localparam int unsigned ADDR_W = 19;
    localparam int unsigned DATA_W = 8;

    // fastest grade figures, picoseconds
    localparam int unsigned T_RC_PS  = 45000;
    localparam int unsigned T_AA_PS  = 45000;
    localparam int unsigned T_OE_PS  = 22000;
    localparam int unsigned T_HZ_PS  = 18000;
    localparam int unsigned T_OHZ_PS = 18000;
    localparam int unsigned T_WC_PS  = 45000;
    localparam int unsigned T_CW_PS  = 35000;
    localparam int unsigned T_AW_PS  = 35000;
    localparam int unsigned T_WP_PS  = 35000;
    localparam int unsigned T_DW_PS  = 25000;
    localparam int unsigned T_WZ_PS  = 18000;
    localparam int unsigned T_PD_PS  = 45000;

    // least times round up
    localparam int unsigned RD_CYC  = (T_RC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned WR_CYC  = (T_WC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned WP_CYC  = (T_WP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned DW_CYC  = (T_DW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned WZ_CYC  = (T_WZ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned HZ_CYC  = (T_OHZ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SYNC_CYC = 2;
    // strobe low time covers write pulse, chip-enable and address-valid to end
    localparam int unsigned STROBE_CYC = WP_CYC;
    localparam int unsigned CNT_W = 8;

    typedef enum logic [1:0] {
        ASR_IDLE,
        ASR_READ,
        ASR_WRITE,
        ASR_TURN
    } asr_state_e;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] word_address;
        logic [DATA_W-1:0] wdata;
    } asr_req_s;

    typedef struct packed {
        logic              chip_sel_n;
        logic              out_en_n;
        logic              wr_strobe_n;
        logic [ADDR_W-1:0] word_address;
        logic [DATA_W-1:0] dq_out;
        logic              dq_oe_n;
    } asr_pins_s;

endpackage

// ===== asr_sync.sv
/*
 * two flip-flop synchroniser for the data pins read back from the memory.
 * assumes the input is asynchronous to sys_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module asr_sync #(
    parameter int unsigned W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;

endmodule
`default_nettype wire

// ===== async_sram_512k_by_8_test.sv
/*
 * self-checking testbench for asr_host against asr_mem_model.
 * assumes a 200 MHz clock; inputs change at the falling edge.
 */
`timescale 1ns/100ps
`default_nettype none
module async_sram_512k_by_8_test;
    logic               sys_clk, reset_n, req_valid, req_ready, rd_valid, mem_drive;
    asr_pkg::asr_req_s  req;
    asr_pkg::asr_pins_s pins;
    logic [7:0]         rd_data, mem_data, last_dq;
    logic [18:0]        last_addr;
    logic               prev_cs = 1'b1, prev_we = 1'b1;
    int                 n_errors = 0, num_checks = 0, cycles = 0, wr_low = 0, dat_stab = 0, cs_gap = 99;
    logic [31:0]        lfsr = 32'h00014240;
    logic [7:0]         ref_mem [logic [18:0]];
    logic [18:0]        b_addr [4] = '{19'h00000, 19'h7FFFF, 19'h40000, 19'h2AAAA};
    logic [7:0]         b_data [4] = '{8'hFF, 8'h00, 8'hA5, 8'h5A};
    // a floating bus shows the inverse of the last byte, never the byte itself
    wire  [7:0]         dq_bus = !pins.dq_oe_n ? pins.dq_out : (mem_drive ? mem_data : ~mem_data);

    asr_host u_asr_host (.sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins), .mem_dq_in(dq_bus));
    asr_mem_model u_asr_mem_model (.chip_sel_n(pins.chip_sel_n), .out_en_n(pins.out_en_n),
        .wr_strobe_n(pins.wr_strobe_n), .word_address(pins.word_address), .dq_bus(dq_bus),
        .mem_drive(mem_drive), .mem_data(mem_data));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic chk_val(string name, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // host-side pin timing watched every cycle
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 20000) begin
            n_errors++;
            wrap_up();
        end
        if (reset_n) begin
            if (!pins.chip_sel_n && !prev_cs) chk_val("addr_in_access", last_addr, pins.word_address);
            if (pins.wr_strobe_n && !prev_we) chk_val("strobe_low_ok", 1, wr_low >= 7);
            if (pins.wr_strobe_n && !prev_we) chk_val("data_setup_ok", 1, dat_stab >= 5);
            if (!pins.chip_sel_n && prev_cs) chk_val("cycle_ok", 1, cs_gap >= 9);
            if (!pins.dq_oe_n && mem_drive) chk_val("dq_clash", 0, 1);
        end
        wr_low = !pins.wr_strobe_n ? wr_low + 1 : 0;
        dat_stab = (pins.dq_out === last_dq) ? dat_stab + 1 : 0;
        cs_gap = !reset_n ? 99 : ((!pins.chip_sel_n && prev_cs) ? 1 : cs_gap + 1);
        prev_cs = pins.chip_sel_n;
        prev_we = pins.wr_strobe_n;
        last_addr = pins.word_address;
        last_dq = pins.dq_out;
    end

    // called at a falling edge; returns at a falling edge with the host idle
    task automatic access(logic wr, logic [18:0] a, logic [7:0] d);
        int n;
        req_valid = 1'b1;
        req = '{write: wr, word_address: a, wdata: d};
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        n = 0;
        @(negedge sys_clk);
        req_valid = 1'b0;
        while (!(wr ? req_ready === 1'b1 : rd_valid === 1'b1) && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        chk_val("latency", wr ? 9 : 12, n);
        if (wr) ref_mem[a] = d;
        else chk_val("rd_data", ref_mem.exists(a) ? ref_mem[a] : 8'h00, rd_data);
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
    endtask

    task automatic rand_ops(int k);
        for (int i = 0; i < k; i++) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            access(lfsr[5], {lfsr[10:8], 12'h000, lfsr[3:0]}, lfsr[31:24]);
        end
    endtask

    initial begin
        reset_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        chk_val("reset_pins", 32'h3E, {pins.chip_sel_n, pins.out_en_n, pins.wr_strobe_n, pins.dq_oe_n,
            req_ready, rd_valid});
        reset_n = 1'b1;
        access(1'b0, 19'h00003, 8'h00);
        foreach (b_addr[i]) begin
            access(1'b1, b_addr[i], b_data[i]);
            access(1'b0, b_addr[i], 8'h00);
        end
        $display("test boundary done");
        rand_ops(30);
        $display("test slow random done");
        u_asr_mem_model.t_acc = 12.0;
        rand_ops(30);
        $display("test fast random done");
        req_valid = 1'b1;
        req = '{write: 1'b1, word_address: 19'h12345, wdata: 8'h3C};
        repeat (4) @(negedge sys_clk);
        reset_n = 1'b0;
        req_valid = 1'b0;
        @(negedge sys_clk);
        chk_val("reset_mid_write", 32'h3E, {pins.chip_sel_n, pins.out_en_n, pins.wr_strobe_n, pins.dq_oe_n,
            req_ready, rd_valid});
        reset_n = 1'b1;
        access(1'b0, 19'h7FFFF, 8'h00);
        $display("test reset mid write done");
        wrap_up();
    end
endmodule
`default_nettype wire
